/* File: dv/cpu_model.sv */
// processor-side stand-in: services interrupts, resolves the pin
// assumes the timer core runs on the same clk
`timescale 1ns/10ps
module cpu_model (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic serve,
   input wire logic cmp_irq,
   input wire logic ovf_irq,
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic cmp_irq_ack,
   output logic ovf_irq_ack,
   output logic pin_level
);
   // one ack pulse per request, compare served first
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmp_irq_ack <= 1'b0;
         ovf_irq_ack <= 1'b0;
      end else begin
         cmp_irq_ack <= serve & cmp_irq & ~cmp_irq_ack;
         ovf_irq_ack <= serve & ovf_irq & ~ovf_irq_ack & ~cmp_irq;
      end
   end
   // pull-up holds the pin when nobody drives it
   assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule : cpu_model

/* File: dv/tb.sv */
// self-checking bench for the 8-bit timer core
// assumes one 50 MHz clock, cpu_model as processor and pin
`timescale 1ns/10ps
module tb;
   import timer8_pkg::*;
   logic clk, sys_rst, wr_en, rd_en, prescale_tick, global_irq_enable;
   logic port_data, port_dir, serve, cmp_irq, ovf_irq, cmp_irq_ack;
   logic ovf_irq_ack, pin_out, pin_oe, pin_level;
   addr_t addr;
   byte_t wdata, rdata;
   int bad_count = 0;
   int compares = 0;
   int cycles = 0;

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   timer8_core DUT (.clk(clk), .sys_rst(sys_rst), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .prescale_tick(prescale_tick), .global_irq_enable(global_irq_enable),
      .cmp_irq_ack(cmp_irq_ack), .ovf_irq_ack(ovf_irq_ack),
      .cmp_irq(cmp_irq), .ovf_irq(ovf_irq), .port_data(port_data),
      .port_dir(port_dir), .pin_out(pin_out), .pin_oe(pin_oe));

   cpu_model cpu (.clk(clk), .sys_rst(sys_rst), .serve(serve),
      .cmp_irq(cmp_irq), .ovf_irq(ovf_irq), .pin_out(pin_out),
      .pin_oe(pin_oe), .cmp_irq_ack(cmp_irq_ack),
      .ovf_irq_ack(ovf_irq_ack), .pin_level(pin_level));

   //---------------------------------------------------------------
   // helpers
   //---------------------------------------------------------------
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         $display("ERROR %0t run too long", $time);
         close_out();
      end
   end

   task automatic chk(input byte_t g, input byte_t e, input string m);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask : chk

   task automatic chk_bit(input logic g, input logic e, input string m);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %0t %s got %b exp %b", $time, m, g, e);
      end
   endtask : chk_bit

   function automatic byte_t ctl(logic [2:0] cs, logic [1:0] md,
      logic [1:0] act, logic f);
      return {f, md[0], act, md[1], cs};
   endfunction : ctl

   task automatic wr(input addr_t a, input byte_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input addr_t a, input byte_t e, input string m);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(rdata, e, m);
   endtask : rd

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk);
         prescale_tick <= 1'b1;
         @(posedge clk);
         prescale_tick <= 1'b0;
      end
   endtask : tick

   task automatic settle;
      @(posedge clk);
      #1;
   endtask : settle

   //---------------------------------------------------------------
   // scenarios
   //---------------------------------------------------------------
   task automatic t_reset;
      for (int i = 0; i < 6; i++) begin
         rd(addr_t'(i), 8'h00, "reset or unmapped read");
      end
      chk_bit(pin_level, 1'b1, "port data on pin");
      wr(ADDR_CTRL, ctl(CS_STOP, MODE_NORMAL, ACT_TOGGLE, 1'b0));
      settle();
      chk_bit(pin_level, 1'b0, "output state after reset");
      $display("test reset done");
   endtask : t_reset

   task automatic t_count;
      wr(ADDR_CTRL, ctl(CS_STOP, MODE_NORMAL, ACT_NONE, 1'b0));
      wr(ADDR_COUNT, 8'h05);
      tick(2);
      rd(ADDR_COUNT, 8'h05, "stopped count");
      wr(ADDR_CTRL, ctl(3'h1, MODE_NORMAL, ACT_NONE, 1'b0));
      tick(3);
      rd(ADDR_COUNT, 8'h08, "count up");
      @(posedge clk);
      addr <= ADDR_COUNT;
      wdata <= 8'h40;
      wr_en <= 1'b1;
      prescale_tick <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      prescale_tick <= 1'b0;
      rd(ADDR_COUNT, 8'h40, "write beats tick");
      $display("test count done");
   endtask : t_count

   task automatic t_ovf;
      @(posedge clk);
      global_irq_enable <= 1'b1;
      wr(ADDR_IRQ_EN, 8'h01);
      wr(ADDR_COUNT, MAX_VAL);
      tick(1);
      rd(ADDR_COUNT, BOTTOM_VAL, "wrap to bottom");
      rd(ADDR_FLAGS, 8'h01, "overflow flag");
      chk_bit(ovf_irq, 1'b1, "overflow request");
      wr(ADDR_FLAGS, 8'h01);
      $display("test overflow done");
   endtask : t_ovf

   task automatic t_match;
      wr(ADDR_COMPARE, 8'h05);
      wr(ADDR_IRQ_EN, 8'h02);
      wr(ADDR_COUNT, 8'h05);
      tick(1);
      rd(ADDR_FLAGS, 8'h00, "match blocked by write");
      wr(ADDR_COUNT, 8'h04);
      tick(2);
      rd(ADDR_FLAGS, 8'h02, "match flag");
      rd(ADDR_COUNT, 8'h06, "count past match");
      chk_bit(cmp_irq, 1'b1, "compare request");
      @(posedge clk);
      global_irq_enable <= 1'b0;
      settle();
      chk_bit(cmp_irq, 1'b0, "request masked globally");
      @(posedge clk);
      global_irq_enable <= 1'b1;
      serve <= 1'b1;
      repeat (4) @(posedge clk);
      serve <= 1'b0;
      rd(ADDR_FLAGS, 8'h00, "flag cleared by service");
      wr(ADDR_COUNT, 8'h04);
      tick(2);
      wr(ADDR_FLAGS, 8'h02);
      rd(ADDR_FLAGS, 8'h00, "flag cleared by one");
      $display("test match done");
   endtask : t_match

   task automatic t_output;
      @(posedge clk);
      port_data <= 1'b0;
      wr(ADDR_CTRL, ctl(CS_STOP, MODE_NORMAL, ACT_TOGGLE, 1'b1));
      settle();
      chk_bit(pin_level, 1'b1, "forced toggle");
      rd(ADDR_FLAGS, 8'h00, "force sets no flag");
      wr(ADDR_CTRL, ctl(CS_STOP, MODE_FAST, ACT_TOGGLE, 1'b0));
      settle();
      chk_bit(pin_level, 1'b1, "state kept over mode");
      wr(ADDR_CTRL, ctl(CS_STOP, MODE_NORMAL, ACT_CLEAR, 1'b1));
      settle();
      chk_bit(pin_level, 1'b0, "forced clear");
      wr(ADDR_CTRL, ctl(CS_STOP, MODE_NORMAL, ACT_SET, 1'b1));
      settle();
      chk_bit(pin_level, 1'b1, "forced set");
      wr(ADDR_CTRL, ctl(3'h1, MODE_CTC, ACT_NONE, 1'b0));
      settle();
      chk_bit(pin_level, 1'b0, "no override");
      wr(ADDR_COMPARE, 8'h02);
      wr(ADDR_COUNT, 8'h00);
      tick(3);
      rd(ADDR_COUNT, 8'h00, "clear on match");
      wr(ADDR_CTRL, ctl(3'h1, MODE_CTC, ACT_TOGGLE, 1'b0));
      settle();
      chk_bit(pin_level, 1'b1, "zero action kept state");
      wr(ADDR_COUNT, 8'h01);
      tick(2);
      settle();
      chk_bit(pin_level, 1'b0, "toggle on match");
      @(posedge clk);
      port_dir <= 1'b0;
      settle();
      chk_bit(pin_level, 1'b1, "pin released");
      @(posedge clk);
      port_dir <= 1'b1;
      $display("test output done");
   endtask : t_output

   task automatic t_dbuf;
      wr(ADDR_CTRL, ctl(CS_STOP, MODE_NORMAL, ACT_NONE, 1'b0));
      wr(ADDR_COMPARE, 8'h0a);
      wr(ADDR_CTRL, ctl(3'h1, MODE_FAST, ACT_NONE, 1'b0));
      wr(ADDR_COMPARE, 8'h14);
      rd(ADDR_COMPARE, 8'h14, "buffer read back");
      wr(ADDR_FLAGS, 8'h03);
      wr(ADDR_COUNT, 8'h09);
      tick(2);
      rd(ADDR_FLAGS, 8'h02, "old working compare");
      $display("test buffer done");
   endtask : t_dbuf

   task automatic t_phase;
      wr(ADDR_CTRL, ctl(3'h1, MODE_PHASE, ACT_CLEAR, 1'b0));
      wr(ADDR_COMPARE, 8'hfe);
      wr(ADDR_FLAGS, 8'h03);
      wr(ADDR_COUNT, 8'hfd);
      tick(4);
      rd(ADDR_COUNT, 8'hfd, "phase turn at top");
      rd(ADDR_FLAGS, 8'h02, "buffer loaded at top");
      chk_bit(pin_level, 1'b1, "set on down match");
      wr(ADDR_FLAGS, 8'h03);
      wr(ADDR_COUNT, 8'h01);
      tick(2);
      rd(ADDR_FLAGS, 8'h01, "phase overflow");
      rd(ADDR_COUNT, 8'h01, "phase turn at bottom");
      wr(ADDR_CTRL, ctl(3'h1, MODE_FAST, ACT_SET, 1'b0));
      wr(ADDR_COUNT, MAX_VAL);
      tick(1);
      settle();
      chk_bit(pin_level, 1'b0, "fast clear at bottom");
      $display("test phase done");
   endtask : t_phase

   initial begin
      sys_rst = 1'b1;
      wr_en = 1'b0;
      rd_en = 1'b0;
      prescale_tick = 1'b0;
      global_irq_enable = 1'b0;
      port_data = 1'b1;
      port_dir = 1'b1;
      serve = 1'b0;
      addr = ADDR_CTRL;
      wdata = RESET_BYTE;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_count();
      t_ovf();
      t_match();
      t_output();
      t_dbuf();
      t_phase();
      close_out();
   end
endmodule : tb

/* File: rtl/oc_stage.sv */
// compare output state and pin override
// assumes events are one-cycle pulses from the counter core
`timescale 1ns/10ps
module oc_stage (
   input wire logic clk,
   input wire logic sys_rst,
   wave_if.stage w,
   input wire logic port_data,
   input wire logic port_dir,
   output logic pin_out,
   output logic pin_oe
);
   import timer8_pkg::*;
   logic oc_ff;
   logic nxt_oc;
   wire act_on = (w.action != ACT_NONE);
   wire pwm = (w.mode == MODE_PHASE) || (w.mode == MODE_FAST);
   // match effect; phase mode flips meaning on down slope
   wire phase_set = (w.action == ACT_SET) ^ w.down;
   wire m_val = (w.action == ACT_TOGGLE) ? ~oc_ff :
      (w.mode == MODE_PHASE) ? phase_set : (w.action == ACT_SET);
   wire m_do = (w.match_evt || w.force_evt) && act_on &&
      !((w.mode == MODE_PHASE) && (w.action == ACT_TOGGLE));
   // fast pwm bottom effect wins so extreme compare is steady
   wire b_do = w.wrap_evt && pwm && (w.action[1] == 1'b1);
   wire b_val = (w.action == ACT_CLEAR);
   assign nxt_oc = b_do ? b_val : (m_do ? m_val : oc_ff);
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         oc_ff <= 1'b0;
      end else begin
         oc_ff <= nxt_oc;
      end
   end
   assign w.oc = oc_ff;
   assign pin_out = act_on ? oc_ff : port_data;
   assign pin_oe = port_dir;
   //--------------------------------------------------------------
   // checks
   //--------------------------------------------------------------
   oc_reset_a: assert property (@(posedge clk) disable iff (1'b0)
      sys_rst |=> !oc_ff)
      else $error("output state not cleared by reset");
   oc_mode_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
      ($changed(w.mode) && !w.match_evt && !w.force_evt && !w.wrap_evt)
      |=> $stable(oc_ff))
      else $error("output state moved on mode change");
   pin_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
      pin_out == (act_on ? oc_ff : port_data))
      else $error("pin source wrong");
   act_none_a: assert property (@(posedge clk) disable iff (sys_rst)
      (w.action == ACT_NONE) |=> $stable(oc_ff))
      else $error("output changed with no action");
endmodule : oc_stage

/* File: rtl/timer8_core.sv */
// 8-bit timer/counter with compare unit, registers on strobe port
// assumes prescale_tick, port_data, port_dir come from logic on clk
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module timer8_core (
   input wire logic clk,
   input wire logic sys_rst,
   input wire timer8_pkg::addr_t addr,
   input wire timer8_pkg::byte_t wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output timer8_pkg::byte_t rdata,
   input wire logic prescale_tick,
   input wire logic global_irq_enable,
   input wire logic cmp_irq_ack,
   input wire logic ovf_irq_ack,
   output logic cmp_irq,
   output logic ovf_irq,
   input wire logic port_data,
   input wire logic port_dir,
   output logic pin_out,
   output logic pin_oe
);
   import timer8_pkg::*;
   //--------------------------------------------------------------
   // state
   //--------------------------------------------------------------
   byte_t ctrl_ff;
   byte_t count_ff;
   byte_t compare_ff;
   byte_t cmp_buf_ff;
   byte_t rdata_ff;
   logic cmp_flag_ff;
   logic ovf_flag_ff;
   logic cmp_ie_ff;
   logic ovf_ie_ff;
   logic down_ff;
   logic block_ff;
   logic force_ff;
   byte_t nxt_count;
   byte_t nxt_compare;
   byte_t nxt_buf;
   logic nxt_down;
   logic nxt_block;
   logic nxt_cmp_flag;
   logic nxt_ovf_flag;
   logic nxt_force;
   wave_if w ();
   //--------------------------------------------------------------
   // decode
   //--------------------------------------------------------------
   wire wr_ctrl = wr_en && (addr == ADDR_CTRL);
   wire wr_count = wr_en && (addr == ADDR_COUNT);
   wire wr_cmp = wr_en && (addr == ADDR_COMPARE);
   wire wr_flags = wr_en && (addr == ADDR_FLAGS);
   wire wr_ie = wr_en && (addr == ADDR_IRQ_EN);
   wire [2:0] tick_source_select = ctrl_ff[CS_MSB:CS_LSB];
   wire waveform_mode_bit_high = ctrl_ff[WGM_HI_POS];
   wire waveform_mode_bit_low = ctrl_ff[WGM_LO_POS];
   wire [1:0] waveform_mode_select =
      {waveform_mode_bit_high, waveform_mode_bit_low};
   wire [1:0] compare_output_action = ctrl_ff[COM_MSB:COM_LSB];
   wire pwm_mode = (waveform_mode_select == MODE_PHASE) ||
      (waveform_mode_select == MODE_FAST);
   wire [1:0] wr_mode = {wdata[WGM_HI_POS], wdata[WGM_LO_POS]};
   wire wr_pwm = (wr_mode == MODE_PHASE) || (wr_mode == MODE_FAST);
   //--------------------------------------------------------------
   // tick, extremes, comparator
   //--------------------------------------------------------------
   wire timer_tick = (tick_source_select != CS_STOP) &&
      prescale_tick;
   wire at_max = (count_ff == MAX_VAL);
   wire at_bottom = (count_ff == BOTTOM_VAL);
   wire match = (count_ff == compare_ff);
   wire match_ok = timer_tick && match && !block_ff;
   wire is_phase = (waveform_mode_select == MODE_PHASE);
   wire is_ctc = (waveform_mode_select == MODE_CTC);
   wire is_fast = (waveform_mode_select == MODE_FAST);
   wire byte_t cnt_inc = count_ff + ONE_VAL;
   wire byte_t cnt_dec = count_ff - ONE_VAL;
   // phase mode turns at max and bottom
   wire going_down = is_phase &&
      ((down_ff && !at_bottom) || (!down_ff && at_max));
   wire byte_t cnt_step = (is_ctc && match_ok) ? BOTTOM_VAL :
      (going_down ? cnt_dec : cnt_inc);
   assign nxt_count = wr_count ? wdata :
      (timer_tick ? cnt_step : count_ff);
   assign nxt_down = wr_count ? down_ff :
      (timer_tick ? going_down : (is_phase && down_ff));
   assign nxt_block = wr_count ? 1'b1 :
      (timer_tick ? 1'b0 : block_ff);
   //--------------------------------------------------------------
   // flags
   //--------------------------------------------------------------
   wire ovf_evt = timer_tick && !wr_count &&
      (is_phase ? (at_bottom && down_ff) : at_max);
   wire cmp_clr = (wr_flags && wdata[FLAG_CMP_POS]) || cmp_irq_ack;
   wire ovf_clr = (wr_flags && wdata[FLAG_OVF_POS]) || ovf_irq_ack;
   // set wins over a clear in the same cycle
   assign nxt_cmp_flag = match_ok || (cmp_flag_ff && !cmp_clr);
   assign nxt_ovf_flag = ovf_evt || (ovf_flag_ff && !ovf_clr);
   assign cmp_irq = cmp_flag_ff && cmp_ie_ff &&
      global_irq_enable;
   assign ovf_irq = ovf_flag_ff && ovf_ie_ff && global_irq_enable;
   //--------------------------------------------------------------
   // compare value and its buffer
   //--------------------------------------------------------------
   wire buf_load = pwm_mode && timer_tick && at_max;
   assign nxt_buf = wr_cmp ? wdata : cmp_buf_ff;
   assign nxt_compare = buf_load ? cmp_buf_ff :
      ((wr_cmp && !pwm_mode) ? wdata : compare_ff);
   // force takes effect after ctrl holds the new action bits
   assign nxt_force = wr_ctrl && wdata[FORCE_POS] && !wr_pwm;
   //--------------------------------------------------------------
   // read mux
   //--------------------------------------------------------------
   wire byte_t ctrl_rd = {1'b0, ctrl_ff[FORCE_POS-1:0]};
   wire byte_t cmp_rd = pwm_mode ? cmp_buf_ff : compare_ff;
   wire byte_t flags_rd = (RESET_BYTE | (byte_t'(cmp_flag_ff) <<
      FLAG_CMP_POS) | (byte_t'(ovf_flag_ff) << FLAG_OVF_POS));
   wire byte_t ie_rd = (RESET_BYTE | (byte_t'(cmp_ie_ff) <<
      FLAG_CMP_POS) | (byte_t'(ovf_ie_ff) << FLAG_OVF_POS));
   wire byte_t rd_mux = (addr == ADDR_CTRL) ? ctrl_rd :
      (addr == ADDR_COUNT) ? count_ff :
      (addr == ADDR_COMPARE) ? cmp_rd :
      (addr == ADDR_FLAGS) ? flags_rd :
      (addr == ADDR_IRQ_EN) ? ie_rd : RESET_BYTE;
   assign rdata = rdata_ff;
   //--------------------------------------------------------------
   // registers
   //--------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_ff <= RESET_BYTE;
         count_ff <= RESET_BYTE;
         compare_ff <= RESET_BYTE;
         cmp_buf_ff <= RESET_BYTE;
         rdata_ff <= RESET_BYTE;
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= wdata;
         end
         count_ff <= nxt_count;
         compare_ff <= nxt_compare;
         cmp_buf_ff <= nxt_buf;
         rdata_ff <= rd_en ? rd_mux : RESET_BYTE;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmp_flag_ff <= 1'b0;
         ovf_flag_ff <= 1'b0;
         down_ff <= 1'b0;
         block_ff <= 1'b0;
         force_ff <= 1'b0;
      end else begin
         cmp_flag_ff <= nxt_cmp_flag;
         ovf_flag_ff <= nxt_ovf_flag;
         down_ff <= nxt_down;
         block_ff <= nxt_block;
         force_ff <= nxt_force;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cmp_ie_ff <= 1'b0;
         ovf_ie_ff <= 1'b0;
      end else if (wr_ie) begin
         cmp_ie_ff <= wdata[FLAG_CMP_POS];
         ovf_ie_ff <= wdata[FLAG_OVF_POS];
      end
   end
   //--------------------------------------------------------------
   // output stage
   //--------------------------------------------------------------
   assign w.match_evt = match_ok;
   assign w.force_evt = force_ff;
   assign w.wrap_evt = timer_tick && is_fast && at_max;
   assign w.down = down_ff;
   assign w.mode = waveform_mode_select;
   assign w.action = compare_output_action;
   oc_stage u_stage (
      .clk(clk),
      .sys_rst(sys_rst),
      .w(w),
      .port_data(port_data),
      .port_dir(port_dir),
      .pin_out(pin_out),
      .pin_oe(pin_oe)
   );
   //--------------------------------------------------------------
   // checks
   //--------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence cnt_write_s;
      wr_count ##1 1'b1;
   endsequence
   sequence blocked_tick_s;
      block_ff && timer_tick && !cmp_flag_ff;
   endsequence
   stop_hold_a: assert property ((tick_source_select == CS_STOP) &&
      !wr_count |=> $stable(count_ff))
      else $error("counter moved while stopped");
   cnt_write_a: assert property (wr_count |=>
      count_ff == $past(wdata))
      else $error("count write lost");
   block_set_a: assert property (cnt_write_s |-> block_ff)
      else $error("count write did not block");
   block_hit_a: assert property (blocked_tick_s |=>
      !cmp_flag_ff)
      else $error("blocked match set flag");
   match_flag_a: assert property (timer_tick && match && !block_ff
      |=> cmp_flag_ff)
      else $error("match did not set flag");
   flag_clear_a: assert property (wr_flags && wdata[FLAG_CMP_POS] &&
      !match_ok |=> !cmp_flag_ff)
      else $error("flag not cleared by write");
   irq_gate_a: assert property (cmp_irq == (cmp_flag_ff && cmp_ie_ff
      && global_irq_enable))
      else $error("compare interrupt gating wrong");
   ovf_norm_a: assert property (timer_tick && !wr_count &&
      (waveform_mode_select == MODE_NORMAL) && at_max
      |=> ovf_flag_ff && count_ff == BOTTOM_VAL)
      else $error("overflow not flagged at wrap");
   buf_hold_a: assert property (pwm_mode && !buf_load
      |=> $stable(compare_ff))
      else $error("buffered compare changed off top");
   up_step_a: assert property (timer_tick && !wr_count &&
      (waveform_mode_select == MODE_NORMAL)
      |=> count_ff == $past(cnt_inc))
      else $error("normal mode did not increment");
   sequence top_turn_s;
      is_phase && timer_tick && !wr_count && at_max && !down_ff;
   endsequence
   phase_turn_a: assert property (top_turn_s |=> down_ff &&
      count_ff == (MAX_VAL - ONE_VAL))
      else $error("phase mode did not turn at top");
   buf_load_a: assert property (buf_load |=>
      compare_ff == $past(cmp_buf_ff))
      else $error("buffered compare not loaded at top");
   ovf_phase_a: assert property (is_phase && timer_tick && !wr_count &&
      at_bottom && down_ff |=> ovf_flag_ff)
      else $error("phase overflow not flagged at bottom");
   force_out_a: assert property (force_ff &&
      (compare_output_action == ACT_SET) |=> w.oc)
      else $error("forced set did not reach output");
endmodule : timer8_core

/* File: rtl/timer8_pkg.sv */
// constants, register map and field layout of the 8-bit timer core
// assumes one clock domain, registers reached over a plain strobe port
// Contract
// - stopped tick source holds counter value
// - each tick clears, increments or decrements counter
// - software reads and writes count anytime
// - software count write beats count/clear
// - waveform mode bits select counting sequence
// - overflow flag set per mode, requests interrupt
// - comparator flags count equal to compare
// - match sets compare flag at tick
// - flag interrupts when enabled, cleared on service
// - writing one clears compare match flag
// - waveform uses match, mode, action, extremes
// - compare double buffered only in pwm modes
// - buffered compare loads only at top
// - compare access hits buffer or working value
// - force strobe acts like match, no flag; code drops it when the ctrl write selects a pwm mode
// - count write blocks match next tick
// - output state kept across mode change
// - action bits take effect immediately
// - action bits choose match effect, pin source
// - reset clears output state to zero
// - nonzero action overrides port data on pin
// - pin override ignores waveform mode
// - bottom is 0x00, max is 0xff
// - zero action never changes output state
package timer8_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] addr_t;
   //--------------------------------------------------------------
   // register offsets
   //--------------------------------------------------------------
   localparam addr_t ADDR_CTRL = 3'h0;
   localparam addr_t ADDR_COUNT = 3'h1;
   localparam addr_t ADDR_COMPARE = 3'h2;
   localparam addr_t ADDR_FLAGS = 3'h3;
   localparam addr_t ADDR_IRQ_EN = 3'h4;
   //--------------------------------------------------------------
   // field positions
   //--------------------------------------------------------------
   localparam int CS_LSB = 0;
   localparam int CS_MSB = 2;
   localparam int WGM_HI_POS = 3;
   localparam int COM_LSB = 4;
   localparam int COM_MSB = 5;
   localparam int WGM_LO_POS = 6;
   localparam int FORCE_POS = 7;
   localparam int FLAG_OVF_POS = 0;
   localparam int FLAG_CMP_POS = 1;
   //--------------------------------------------------------------
   // values
   //--------------------------------------------------------------
   localparam byte_t BOTTOM_VAL = 8'h00;
   localparam byte_t MAX_VAL = 8'hff;
   localparam byte_t RESET_BYTE = 8'h00;
   localparam byte_t ONE_VAL = 8'h01;
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_PHASE = 2'h1;
   localparam logic [1:0] MODE_CTC = 2'h2;
   localparam logic [1:0] MODE_FAST = 2'h3;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
endpackage : timer8_pkg

/* File: rtl/wave_if.sv */
// events and settings passed from counter core to output stage
// assumes both ends on the same clock
`timescale 1ns/10ps
interface wave_if;
   logic match_evt;
   logic force_evt;
   logic wrap_evt;
   logic down;
   logic [1:0] mode;
   logic [1:0] action;
   logic oc;
   modport core (output match_evt, force_evt, wrap_evt, down, mode,
      action, input oc);
   modport stage (input match_evt, force_evt, wrap_evt, down, mode,
      action, output oc);
endinterface : wave_if
